// >>> src/sra_device.sv
// Converter end: rotation action control and its registers
// What this block does
// - Alignment logic enable resets 1; keep 1
// - Reserved bit 6 resets 0; write 1
// - Periodic reset enable resets 1; keep 1
// - Oscillator reset after digital reset, rotation
// - Oscillator sync start also resets all oscillators
// - Action bit 0 resets, realigns SERDES clocks
// - SERDES reset drops links; transmitter relinks
// - Software should set SERDES clock reset action
// - Action bit 1 ramps datapath off, on
// - Ramp action only with amplifier protection
// - Action zero: no SERDES or datapath action
// - Action 11: both SERDES reset and ramp
// - One-shot: one rotation, then monitor mode
// - Read-only rotation done flag, resets 1
`timescale 1ns/100ps
`default_nettype none
module sra_device
  import sra_pkg::*;
#(
  parameter int SERDES_CYC = SERDES_RST_CYC,
  parameter int NCO_CYC = NCO_RST_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Link to the controlling party
  sra_link_if.dev lnk,
  // Converter side
  output logic serdes_clk_rst_o,
  output logic nco_rst_o,
  output logic [GAIN_W-1:0] datapath_gain_o,
  output logic rot_done_o
);
  localparam logic [7:0] SERDES_LAST = 8'(SERDES_CYC - 1);
  localparam logic [7:0] NCO_LOAD = 8'(NCO_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // Refused at elaboration: both counters are eight bits wide
  if (SERDES_CYC < 1 || SERDES_CYC > 255 || NCO_CYC < 1 || NCO_CYC > 255)
  begin : g_bad_count
    $error("sra_device: counts must lie in 1..255");
  end

  logic [7:0] rot_ctrl_q;
  logic oneshot_q;
  logic [1:0] act_q;
  logic nco_after_q;
  sra_rot_state_t state_q;
  logic [7:0] cnt_q;
  logic [7:0] nco_cnt_q;
  logic post_rst_q;
  logic ack_q;
  logic [7:0] rdata_q;
  logic sref_s1_q;
  logic sref_s2_q;
  logic sref_s3_q;
  logic serdes_q;
  logic sref_rise;
  logic trigger;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_nco;
  logic ramp_at_zero;
  logic ramp_at_full;
  logic ramp_off;

  assign wr_ctrl = lnk.reg_wr && lnk.reg_addr == ADDR_ROT_CTRL;
  assign wr_mode = lnk.reg_wr && lnk.reg_addr == ADDR_SYSREF_MODE;
  assign wr_nco = lnk.reg_wr && lnk.reg_addr == ADDR_NCO_SYNC;

  // Bits 7, 5 and 4 come out of reset set; bit 6 comes out clear and software sets it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rot_ctrl_q <= ROT_CTRL_RST;
    else if (wr_ctrl)
      rot_ctrl_q <= lnk.reg_wdata & ROT_CTRL_WMASK;
  end

  // SYSREF arrives from outside and is resynchronised before the edge detector
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sref_s1_q <= 1'b0;
      sref_s2_q <= 1'b0;
      sref_s3_q <= 1'b0;
    end
    else
    begin
      sref_s1_q <= lnk.sysref;
      sref_s2_q <= sref_s1_q;
      sref_s3_q <= sref_s2_q;
    end
  end
  assign sref_rise = sref_s2_q && !sref_s3_q;

  // Rotation only runs with the alignment logic and periodic reset both on
  assign trigger = state_q == ST_IDLE && sref_rise && oneshot_q &&
                   rot_ctrl_q[BIT_SYNC_EN] && rot_ctrl_q[BIT_PER_RST];

  // A software write in the same cycle as the hardware clear wins
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      oneshot_q <= 1'b0;
    else if (wr_mode)
      oneshot_q <= lnk.reg_wdata[BIT_ONESHOT];
    else if (trigger)
      oneshot_q <= 1'b0;
  end

  // Field values are frozen for the whole rotation
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      act_q <= ACT_NONE;
      nco_after_q <= 1'b0;
    end
    else if (trigger)
    begin
      act_q <= rot_ctrl_q[BIT_ACT_RAMP:BIT_ACT_SERDES];
      nco_after_q <= rot_ctrl_q[BIT_NCO_ROT];
    end
  end

  // Rotation sequence: optional ramp down, rotation window, optional ramp up
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (trigger && rot_ctrl_q[BIT_ACT_RAMP])
            state_q <= ST_DOWN;
          else if (trigger)
          begin
            state_q <= ST_ROT;
            cnt_q <= SERDES_LAST;
          end
        end
        ST_DOWN:
        begin
          if (ramp_at_zero)
          begin
            state_q <= ST_ROT;
            cnt_q <= SERDES_LAST;
          end
        end
        ST_ROT:
        begin
          if (cnt_q != CNT_ZERO)
            cnt_q <= cnt_q - CNT_ONE;
          else if (act_q[BIT_ACT_RAMP])
            state_q <= ST_UP;
          else
            state_q <= ST_IDLE;
        end
        ST_UP:
        begin
          if (ramp_at_full)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Links drop and SERDES clocks reset only inside the rotation window
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      serdes_q <= 1'b0;
    else
      serdes_q <= (state_q == ST_ROT && cnt_q != CNT_ZERO && act_q[BIT_ACT_SERDES]) ||
                  (state_q == ST_DOWN && ramp_at_zero && act_q[BIT_ACT_SERDES]) ||
                  (state_q == ST_IDLE && trigger && !rot_ctrl_q[BIT_ACT_RAMP] &&
                   rot_ctrl_q[BIT_ACT_SERDES]);
  end
  assign serdes_clk_rst_o = serdes_q;
  assign lnk.link_drop = serdes_q;

  // Digital reset is seen as the first cycle after the reset release
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      post_rst_q <= 1'b1;
    else
      post_rst_q <= 1'b0;
  end

  // One pulse covers main and channel oscillators alike
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      nco_cnt_q <= CNT_ZERO;
    else if (post_rst_q && rot_ctrl_q[BIT_NCO_ROT])
      nco_cnt_q <= NCO_LOAD;
    else if (state_q == ST_ROT && cnt_q == CNT_ZERO && nco_after_q)
      nco_cnt_q <= NCO_LOAD;
    else if (wr_nco && lnk.reg_wdata[BIT_NCO_START])
      nco_cnt_q <= NCO_LOAD;
    else if (nco_cnt_q != CNT_ZERO)
      nco_cnt_q <= nco_cnt_q - CNT_ONE;
  end
  assign nco_rst_o = (nco_cnt_q != CNT_ZERO);

  assign ramp_off = (state_q == ST_DOWN) || (state_q == ST_ROT && act_q[BIT_ACT_RAMP]);
  sra_gain_ramp #(
    .GW(GAIN_W),
    .DIV(RAMP_DIV)
  ) u_ramp (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ramp_off_i(ramp_off),
    .gain_o(datapath_gain_o),
    .at_zero_o(ramp_at_zero),
    .at_full_o(ramp_at_full)
  );

  assign rot_done_o = (state_q == ST_IDLE);
  assign lnk.rot_busy = (state_q != ST_IDLE);

  // Register port answers one cycle after each strobe; unmapped reads give zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= BYTE_ZERO;
    end
    else
    begin
      ack_q <= lnk.reg_wr || lnk.reg_rd;
      if (lnk.reg_rd && lnk.reg_addr == ADDR_ROT_CTRL)
        rdata_q <= rot_ctrl_q;
      else if (lnk.reg_rd && lnk.reg_addr == ADDR_SYSREF_MODE)
      begin
        rdata_q <= BYTE_ZERO;
        rdata_q[BIT_ROT_DONE] <= (state_q == ST_IDLE);
        rdata_q[BIT_ONESHOT] <= oneshot_q;
      end
      else if (lnk.reg_rd)
        rdata_q <= BYTE_ZERO;
    end
  end
  assign lnk.reg_ack = ack_q;
  assign lnk.reg_rdata = rdata_q;
endmodule : sra_device
`default_nettype wire

// >>> src/sra_pkg.sv
// Shared constants and types of the rotation action control block
package sra_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] ADDR_SYSREF_MODE = 12'h03A;
  localparam logic [11:0] ADDR_ROT_CTRL = 12'h03B;
  localparam logic [11:0] ADDR_NCO_SYNC = 12'h1E7;
  localparam int BIT_SYNC_EN = 7;
  localparam int BIT_RSVD6 = 6;
  localparam int BIT_PER_RST = 5;
  localparam int BIT_NCO_ROT = 4;
  localparam int BIT_ACT_SERDES = 0;
  localparam int BIT_ACT_RAMP = 1;
  localparam int BIT_ONESHOT = 1;
  localparam int BIT_ROT_DONE = 4;
  localparam int BIT_NCO_START = 0;
  localparam logic [7:0] ROT_CTRL_RST = 8'hB0;
  localparam logic [7:0] ROT_CTRL_WMASK = 8'hF3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam int SERDES_RST_CYC = 16;
  localparam int NCO_RST_CYC = 4;
  localparam int RAMP_DIV = 4;
  localparam int GAIN_W = 8;
  localparam int SYSREF_PERIOD = 64;
  localparam int SYSREF_HIGH = 4;
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_CFG = 4'h4;
  localparam logic [3:0] AV_STAT = 4'h8;
  localparam logic [3:0] CFG_RST = 4'h3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DOWN = 2'b01,
    ST_ROT = 2'b10,
    ST_UP = 2'b11
  } sra_rot_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01
  } sra_host_state_t;
endpackage : sra_pkg

// >>> src/sra_link_if.sv
// Connection between the converter's rotation control and its controlling party
`timescale 1ns/100ps
`default_nettype none
interface sra_link_if;
  import sra_pkg::*;
  logic reg_wr;
  logic reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_ack;
  logic sysref;
  logic link_drop;
  logic rot_busy;
  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, sysref,
    output reg_rdata, reg_ack, link_drop, rot_busy
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, sysref,
    input reg_rdata, reg_ack, link_drop, rot_busy
  );
endinterface : sra_link_if
`default_nettype wire

// >>> src/sra_gain_ramp.sv
// Soft gain ramp toward zero or full scale, one step per divider tick
`timescale 1ns/100ps
`default_nettype none
module sra_gain_ramp
  import sra_pkg::*;
#(
  parameter int GW = GAIN_W,
  parameter int DIV = RAMP_DIV
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic ramp_off_i,
  // Status and gain
  output logic [GW-1:0] gain_o,
  output logic at_zero_o,
  output logic at_full_o
);
  localparam logic [GW-1:0] GAIN_FULL = {GW{1'b1}};
  localparam logic [GW-1:0] GAIN_ZERO = {GW{1'b0}};
  localparam logic [GW-1:0] GAIN_STEP = {{(GW-1){1'b0}}, 1'b1};
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
  // Refused at elaboration: the divider counter is sixteen bits wide
  if (GW < 2 || DIV < 1 || DIV > 65536)
  begin : g_bad_param
    $error("sra_gain_ramp: unsupported width or divider");
  end
  logic [15:0] div_q;
  logic tick;
  logic [GW-1:0] gain_q;
  assign tick = (div_q == DIV_LAST);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      div_q <= 16'h0000;
    else if (tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end
  // Stepping slowly keeps the amplifier from seeing a hard edge
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      gain_q <= GAIN_FULL;
    else if (tick && ramp_off_i && gain_q != GAIN_ZERO)
      gain_q <= gain_q - GAIN_STEP;
    else if (tick && !ramp_off_i && gain_q != GAIN_FULL)
      gain_q <= gain_q + GAIN_STEP;
  end
  assign gain_o = gain_q;
  assign at_zero_o = (gain_q == GAIN_ZERO);
  assign at_full_o = (gain_q == GAIN_FULL);
endmodule : sra_gain_ramp
`default_nettype wire

// >>> src/sra_host.sv
// Controlling end: Avalon-MM command registers, register sequencer, SYSREF source
`timescale 1ns/100ps
`default_nettype none
module sra_host
  import sra_pkg::*;
#(
  parameter int SREF_PERIOD = SYSREF_PERIOD,
  parameter int SREF_HIGH = SYSREF_HIGH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Link to the converter
  sra_link_if.host lnk,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Link status
  output logic link_up_o
);
  localparam logic [15:0] SREF_LAST = 16'(SREF_PERIOD - 1);
  localparam logic [15:0] SREF_HI = 16'(SREF_HIGH);
  // Refused at elaboration: the period counter is sixteen bits wide
  if (SREF_HIGH < 1 || SREF_HIGH >= SREF_PERIOD || SREF_PERIOD > 65536)
  begin : g_bad_sref
    $error("sra_host: bad SYSREF period or width");
  end
  logic av_ack_q;
  logic [31:0] rdata_q;
  logic [3:0] cfg_q;
  logic [3:0] pend_q;
  logic [1:0] op_q;
  logic [7:0] stat_q;
  logic link_up_q;
  sra_host_state_t st_q;
  logic [15:0] sref_q;
  logic av_wr;
  logic [3:0] serve;
  logic [7:0] ctrl_val;

  // Waitrequest drops one cycle after the request; writes act at the edge after it drops
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !av_ack_q;
  assign av_wr = avs_write_i && av_ack_q && avs_byteenable_i[0];
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      av_ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      av_ack_q <= (avs_read_i || avs_write_i) && !av_ack_q;
      rdata_q <= 32'h0000_0000;
      if (avs_address_i == AV_CFG)
        rdata_q[3:0] <= cfg_q;
      else if (avs_address_i == AV_STAT)
        rdata_q[11:0] <= {pend_q, stat_q};
      else if (avs_address_i == AV_CMD)
        rdata_q[5:0] <= {link_up_q, lnk.rot_busy, pend_q};
    end
  end
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cfg_q <= CFG_RST;
    else if (av_wr && avs_address_i == AV_CFG)
      cfg_q <= avs_writedata_i[3:0];
  end

  // Fixed-one bits always written as one; ramp only with amplifier protection
  assign ctrl_val = {1'b1, 1'b1, 1'b1, cfg_q[0], 2'b00,
                     cfg_q[2] && cfg_q[3], cfg_q[1]};

  // One command at a time, lowest bit first; a new request beats its own clear
  assign serve = (st_q == H_IDLE) ? (pend_q & (~pend_q + 4'h1)) : 4'h0;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pend_q <= 4'h0;
    else if (av_wr && avs_address_i == AV_CMD)
      pend_q <= (pend_q & ~serve) | avs_writedata_i[3:0];
    else
      pend_q <= pend_q & ~serve;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= H_IDLE;
      op_q <= 2'h0;
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      lnk.reg_addr <= ADDR_ROT_CTRL;
      lnk.reg_wdata <= BYTE_ZERO;
      stat_q <= BYTE_ZERO;
    end
    else
    begin
      lnk.reg_wr <= 1'b0;
      lnk.reg_rd <= 1'b0;
      case (st_q)
        H_IDLE:
        begin
          if (serve != 4'h0)
          begin
            st_q <= H_WAIT;
            lnk.reg_wr <= !serve[3];
            lnk.reg_rd <= serve[3];
            lnk.reg_wdata <= serve[0] ? ctrl_val :
                             serve[1] ? 8'h02 : 8'h01;
            lnk.reg_addr <= serve[0] ? ADDR_ROT_CTRL :
                            serve[2] ? ADDR_NCO_SYNC : ADDR_SYSREF_MODE;
            op_q <= {1'b0, serve[3]};
          end
        end
        H_WAIT:
        begin
          if (lnk.reg_ack)
          begin
            st_q <= H_IDLE;
            if (op_q[0])
              stat_q <= lnk.reg_rdata;
          end
        end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  // Free-running SYSREF pulse train
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sref_q <= 16'h0000;
    else if (sref_q == SREF_LAST)
      sref_q <= 16'h0000;
    else
      sref_q <= sref_q + 16'h0001;
  end
  assign lnk.sysref = (sref_q < SREF_HI);

  // Link comes back once the converter releases the drop
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      link_up_q <= 1'b0;
    else
      link_up_q <= !lnk.link_drop;
  end
  assign link_up_o = link_up_q;
endmodule : sra_host
`default_nettype wire

// >>> tb/sra_checker.sv
// Concurrent checks on the link between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module sra_checker
  import sra_pkg::*;
#(
  parameter int SERDES_CYC = SERDES_RST_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Link signals
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic sysref,
  input wire logic link_drop,
  input wire logic rot_busy
);
  logic armed_q;
  logic [7:0] drop_cnt_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // One-shot request as software last left it; a rotation consumes it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      armed_q <= 1'b0;
    else if (reg_wr && reg_addr == ADDR_SYSREF_MODE)
      armed_q <= reg_wdata[BIT_ONESHOT];
    else if (rot_busy)
      armed_q <= 1'b0;
  end
  // Length of the current link drop
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      drop_cnt_q <= 8'h00;
    else
      drop_cnt_q <= link_drop ? drop_cnt_q + 8'h01 : 8'h00;
  end
  a_ack_after_strobe:
    assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("strobe not acknowledged");
  a_ack_has_cause:
    assert property ($rose(reg_ack) |-> $past(reg_wr) || $past(reg_rd)) else $error("stray acknowledge");
  a_ack_single:
    assert property (reg_ack |=> !reg_ack) else $error("acknowledge longer than one cycle");
  a_mode_readback:
    assert property ((reg_rd && reg_addr == ADDR_SYSREF_MODE) |=> reg_rdata ==
      {3'b000, !$past(rot_busy), 2'b00, $past(armed_q) && !$past(rot_busy), 1'b0})
      else $error("mode register read wrong");
  a_ctrl_fixed_ones:
    assert property ((reg_wr && reg_addr == ADDR_ROT_CTRL) |->
      reg_wdata[BIT_SYNC_EN] && reg_wdata[BIT_RSVD6] && reg_wdata[BIT_PER_RST])
      else $error("control write clears a fixed-one bit");
  a_drop_in_busy:
    assert property ($rose(link_drop) |-> rot_busy) else $error("links dropped outside rotation");
  a_drop_length:
    assert property ($fell(link_drop) |-> drop_cnt_q == SERDES_CYC)
      else $error("link drop length wrong");
  a_oneshot_armed:
    assert property ($rose(rot_busy) |-> armed_q) else $error("rotation without one-shot");
  a_busy_after_sysref:
    assert property ($rose(rot_busy) |-> $past(sysref, 2) || $past(sysref, 3) || $past(sysref, 4))
      else $error("rotation not after sysref");
endmodule : sra_checker
`default_nettype wire

// >>> tb/sync_rotation_action_control_bench.sv
// Bench of the rotation action control, both ends joined
`timescale 1ns/100ps
`default_nettype none
module sync_rotation_action_control_bench
  import sra_pkg::*;
;
  localparam int SER = 16;
  localparam int NCO = 4;
  logic clk, rst, av_rd, av_wr, av_wait, link_up, serdes_rst, nco_rst, rot_done, busy_q;
  logic [3:0] av_addr, av_be;
  logic [31:0] av_wdata, av_rdata, q;
  logic [7:0] gain;
  int err_total = 0;
  int checked = 0;
  int drop_cyc = 0;
  int zero_cyc = 0;
  int nco_cyc = 0;
  int lu_low = 0;
  int rot_cnt = 0;
  int ser_cyc = 0;
  int n0;
  sra_link_if lnk ();
  sra_device #(.SERDES_CYC(SER), .NCO_CYC(NCO)) i_sra_device (.sys_clk_i(clk), .sys_rst_i(rst),
    .lnk(lnk), .serdes_clk_rst_o(serdes_rst), .nco_rst_o(nco_rst), .datapath_gain_o(gain),
    .rot_done_o(rot_done));
  // Short SYSREF period keeps the run brief
  sra_host #(.SREF_PERIOD(32), .SREF_HIGH(4)) i_sra_host (.sys_clk_i(clk), .sys_rst_i(rst),
    .lnk(lnk), .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(av_wdata), .avs_byteenable_i(av_be), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(av_wait), .link_up_o(link_up));
  sra_checker #(.SERDES_CYC(SER)) i_sra_checker (.sys_clk_i(clk), .sys_rst_i(rst),
    .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack), .sysref(lnk.sysref),
    .link_drop(lnk.link_drop), .rot_busy(lnk.rot_busy));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Event counters; scenarios judge their differences
  always @(posedge clk)
  begin
    busy_q <= lnk.rot_busy;
    if (!rst)
    begin
      if (lnk.link_drop === 1'b1) drop_cyc <= drop_cyc + 1;
      if (serdes_rst === 1'b1) ser_cyc <= ser_cyc + 1;
      if (gain === 8'h00) zero_cyc <= zero_cyc + 1;
      if (nco_rst === 1'b1) nco_cyc <= nco_cyc + 1;
      if (link_up === 1'b0) lu_low <= lu_low + 1;
      if (lnk.rot_busy === 1'b1 && busy_q === 1'b0) rot_cnt <= rot_cnt + 1;
    end
  end
  task results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  task tmo(input string nm);
    $display("mismatch %s expected done seen timeout", nm);
    err_total++;
    results();
  endtask : tmo
  // One Avalon transfer; held until waitrequest is sampled low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    av_wr <= wr;
    av_rd <= !wr;
    av_addr <= a;
    av_wdata <= d;
    // Looked at between edges: the value seen is the one the next rising edge samples
    @(negedge clk);
    while (av_wait !== 1'b0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) tmo("bus answer");
    r = av_rdata;
    @(posedge clk);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : av
  // Command write, then poll until nothing is pending
  task cmd(input logic [3:0] b);
    logic [31:0] r;
    int n;
    av(1'b1, AV_CMD, {28'h000_0000, b}, r);
    n = 0;
    r = 32'hFFFF_FFFF;
    while (r[3:0] !== 4'h0 && n < 50)
    begin
      av(1'b0, AV_CMD, 32'h0000_0000, r);
      n++;
    end
    if (n >= 50) tmo("command");
  endtask : cmd
  task wait_rot(input logic change);
    int n;
    n = 0;
    while (lnk.rot_busy !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 500) tmo("rotation start");
    chk("done while busy", 32'h0000_0000, {31'h0000_0000, rot_done});
    if (change)
    begin
      av(1'b1, AV_CFG, 32'h0000_0000, q);
      cmd(4'h1);
    end
    n = 0;
    while (lnk.rot_busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) tmo("rotation end");
  endtask : wait_rot
  task rot_case(input logic [3:0] cfg, input int e_drop, input logic e_ramp, input int e_nco);
    logic [31:0] r;
    int d0, z0, k0, l0, r0, s0;
    av(1'b1, AV_CFG, {28'h000_0000, cfg}, r);
    cmd(4'h1);
    d0 = drop_cyc;
    z0 = zero_cyc;
    k0 = nco_cyc;
    l0 = lu_low;
    r0 = rot_cnt;
    s0 = ser_cyc;
    cmd(4'h2);
    wait_rot(cfg == 4'hF);
    // Later SYSREF edges must not start another rotation
    repeat (100) @(posedge clk);
    cmd(4'h8);
    av(1'b0, AV_STAT, 32'h0000_0000, r);
    chk("rotations", 32'h0000_0001, rot_cnt - r0);
    chk("mode after rotation", 32'h0000_0010, {24'h00_0000, r[7:0]});
    chk("drop cycles", e_drop, drop_cyc - d0);
    chk("serdes reset cycles", e_drop, ser_cyc - s0);
    chk("link down", e_drop > 0, lu_low > l0);
    chk("ramp to zero", e_ramp, zero_cyc > z0);
    chk("gain restored", 32'h0000_00FF, {24'h00_0000, gain});
    chk("osc reset", e_nco, nco_cyc - k0);
  endtask : rot_case
  initial
  begin
    rst = 1'b1;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 4'h0;
    av_wdata = 32'h0000_0000;
    av_be = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("post reset osc", NCO, nco_cyc);
    chk("done flag", 32'h0000_0001, {31'h0000_0000, rot_done});
    av(1'b0, AV_CFG, 32'h0000_0000, q);
    chk("cfg reset", {28'h000_0000, CFG_RST}, {28'h000_0000, q[3:0]});
    cmd(4'h8);
    av(1'b0, AV_STAT, 32'h0000_0000, q);
    chk("mode reset", 32'h0000_0010, {24'h00_0000, q[7:0]});
    av(1'b1, 4'hC, 32'h0000_000F, q);
    av(1'b0, 4'hC, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    av_be <= 4'h0;
    av(1'b1, AV_CFG, 32'h0000_000F, q);
    av_be <= 4'hF;
    av(1'b0, AV_CFG, 32'h0000_0000, q);
    chk("lane masked", 32'h0000_0003, {28'h000_0000, q[3:0]});
    n0 = nco_cyc;
    cmd(4'h4);
    repeat (20) @(posedge clk);
    chk("sync start osc", NCO, nco_cyc - n0);
    rot_case(4'h1, 0, 1'b0, NCO);
    rot_case(4'h2, SER, 1'b0, 0);
    rot_case(4'h4, 0, 1'b0, 0);
    rot_case(4'hC, 0, 1'b1, 0);
    rot_case(4'hF, SER, 1'b1, NCO);
    results();
  end
endmodule : sync_rotation_action_control_bench
`default_nettype wire
